// ### hw/pvdp_port.sv
// Purpose: parallel video data port, general purpose and ITU-R 656 submodes
// Assumes: port clock at most half the system clock; syncs active high
// Notes: ITU status word read from bits [9:2] in 10-bit width
//
// Local design decisions: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module pvdp_port
    import pvdp_pkg::*;
#(
    parameter int CNT_W = 16
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rstn,
    // register port
    input  wire logic [ADDR_W-1:0] regAddr,
    input  wire logic [DATA_W-1:0] regWdata,
    input  wire logic              regWr,
    input  wire logic              regRd,
    output logic      [DATA_W-1:0] regRdata,
    // pins
    input  wire logic              portClock,
    input  pvdp_pins_t             pinIn,
    output pvdp_pins_t             pinOut,
    output logic      [2:0]        fsOe,
    output logic                   dataOe,
    // data mover
    output pvdp_word_t             rxWord,
    input  pvdp_word_t             txWord,
    output logic                   txReady
);

    // sample width mask
    // codes past 8 overflow the shift and so keep all sixteen bits
    function automatic logic [PIN_W-1:0] maskWidth(input logic [PIN_W-1:0] v,
                                                   input logic [3:0] w);
        logic [4:0] bits;
        bits = (w == WID_8) ? 5'd8 : 5'(w) + 5'd8;
        return v & PIN_W'((17'h1 << bits) - 17'h1);
    endfunction : maskWidth

    // general purpose transfer sequencer
    typedef enum {ST_IDLE, ST_DELAY, ST_XFER} pvdp_state_t;

    logic [DATA_W-1:0] control_q;
    logic [CNT_W-1:0]  delay_q, count_q;
    logic              rdPend_q;
    logic [ADDR_W-1:0] rdAddr_q;

    // two-flop synchronisers on all pin inputs
    logic [2:0]        clkSync_q;
    pvdp_pins_t        pinS1_q, pinS2_q;
    logic              fs1Prev_q;

    // sequencer, preamble and capture state
    pvdp_state_t       state_q;
    logic [CNT_W-1:0]  delayCnt_q, xferCnt_q;
    logic [1:0]        trsPos_q;
    logic              synced_q, active_q, vblank_q, field_q;
    logic [CNT_W-1:0]  lineCnt_q, pixCnt_q, capLine_q;
    pvdp_word_t        rx_q;
    pvdp_pins_t        out_q;

    // control fields
    wire       enable   = control_q[CTL_EN];
    wire [2:0] mode     = control_q[CTL_MODE_HI:CTL_MODE_LO];
    wire [1:0] fsNum    = control_q[CTL_FSN_HI:CTL_FSN_LO];
    wire [3:0] width    = control_q[CTL_WID_HI:CTL_WID_LO];
    wire       isItu    = mode[2];
    wire       isOut    = (mode == MODE_GP_OUT);
    wire       isCap    = (mode == MODE_GP_CAP);

    // port clock edge found by sampling
    wire       pclkRise = clkSync_q[1] & ~clkSync_q[2];
    // width mask applied once to the pins, shared by every receive submode; output mode masks its own word
    wire [PIN_W-1:0] din = maskWidth(pinS2_q.data, width);
    wire       fs1Rise  = pinS2_q.fs[0] & ~fs1Prev_q;

    wire [7:0] hi8      = (width == WID_8) ? din[7:0] : din[9:2];
    wire       wOnes    = (hi8 == 8'hFF);
    wire       wZero    = (hi8 == 8'h00);
    wire       trsWord  = (trsPos_q == 2'd3);
    wire       stF      = hi8[6];
    wire       stV      = hi8[5];
    wire       stH      = hi8[4];

    // inside a preamble from its first word onward
    wire       inTrs    = wOnes | (trsPos_q != 2'd0);
    wire       gpIn     = (mode == MODE_GP_IN) | isCap;
    wire       lastXfer = (xferCnt_q == CNT_W'(1));

    // register write decode
    wire wrCtl   = regWr && (regAddr == OFS_CONTROL);
    wire wrDelay = regWr && (regAddr == OFS_DELAY);
    wire wrCount = regWr && (regAddr == OFS_COUNT);

    // register port, read data valid the cycle after the strobe
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            control_q <= CTL_RESET;
            delay_q   <= '0;
            count_q   <= '0;
            rdPend_q  <= 1'b0;
            rdAddr_q  <= '0;
        end else begin
            rdPend_q <= regRd;
            rdAddr_q <= regAddr;
            // writes to unmapped offsets are dropped
            if (wrCtl) begin
                control_q <= regWdata;
            end
            if (wrDelay) begin
                delay_q <= regWdata[CNT_W-1:0];
            end
            if (wrCount) begin
                count_q <= regWdata[CNT_W-1:0];
            end
        end
    end

    // status layout: state, synced, field, blanking, active
    wire [DATA_W-1:0] statusWord = {24'h0, 2'(state_q), synced_q, field_q,
                                    vblank_q, active_q, 2'b00};
    // read data is zero outside the cycle after the strobe
    always_comb begin
        regRdata = '0;
        if (rdPend_q) begin
            unique case (rdAddr_q)
                OFS_CONTROL: regRdata = control_q;
                OFS_DELAY:   regRdata = DATA_W'(delay_q);
                OFS_COUNT:   regRdata = DATA_W'(count_q);
                OFS_STATUS:  regRdata = statusWord;
                default:     regRdata = '0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            clkSync_q <= '0;
            pinS1_q   <= '0;
            pinS2_q   <= '0;
            fs1Prev_q <= 1'b0;
        end else begin
            clkSync_q <= {clkSync_q[1:0], portClock};
            pinS1_q   <= pinIn;
            // second stage moves only on a port clock rise, so each
            // sample is taken once and held for the whole port clock
            if (pclkRise) begin
                pinS2_q   <= pinS1_q;
                // previous level feeds the sync one edge detector
                fs1Prev_q <= pinS2_q.fs[0];
            end
        end
    end

    // sync one or a supplied word opens a transfer
    wire gpStart  = gpIn && fs1Rise;
    wire outStart = isOut && txWord.valid;
    wire noDelay  = (delay_q == '0);
    // output mode only advances on a supplied word
    wire xferStep = !isOut || txWord.valid;
    // a count of zero still moves one word
    wire xferDone = lastXfer || (count_q == '0);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_q    <= ST_IDLE;
            delayCnt_q <= '0;
            xferCnt_q  <= '0;
        // ITU modes do not use the sequencer
        end else if (!enable || isItu) begin
            state_q <= ST_IDLE;
        end else if (pclkRise) begin
            unique case (state_q)
                ST_IDLE: begin
                    if (gpStart || outStart) begin
                        delayCnt_q <= delay_q;
                        xferCnt_q  <= count_q;
                        state_q    <= noDelay ? ST_XFER : ST_DELAY;
                    end
                end
                // one port clock per delay count
                ST_DELAY: begin
                    delayCnt_q <= delayCnt_q - CNT_W'(1);
                    if (delayCnt_q == CNT_W'(1)) begin
                        state_q <= ST_XFER;
                    end
                end
                ST_XFER: begin
                    if (xferStep) begin
                        xferCnt_q <= xferCnt_q - CNT_W'(1);
                        if (xferDone) begin
                            state_q <= ST_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // events carried by the status word
    wire savSeen  = trsWord && !stH && !stV;
    wire fieldOne = trsWord && !stF && stV && field_q;
    wire newFrame = trsWord && !stF && field_q;

    // preamble tracker, line and field state
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            trsPos_q  <= '0;
            synced_q  <= 1'b0;
            active_q  <= 1'b0;
            vblank_q  <= 1'b1;
            field_q   <= 1'b0;
            lineCnt_q <= '0;
        // leaving the ITU modes forces a fresh field one sync
        end else if (!enable || !isItu) begin
            trsPos_q <= '0;
            synced_q <= 1'b0;
            active_q <= 1'b0;
        end else if (pclkRise) begin
            unique case (trsPos_q)
                2'd0: begin
                    trsPos_q <= wOnes ? 2'd1 : 2'd0;
                end
                // two zero words follow the ones word
                2'd1: begin
                    trsPos_q <= wZero ? 2'd2 : 2'd0;
                end
                2'd2: begin
                    trsPos_q <= wZero ? 2'd3 : 2'd0;
                end
                // status word always ends the sequence
                2'd3: begin
                    trsPos_q <= 2'd0;
                end
            endcase
            if (trsWord) begin
                field_q  <= stF;
                vblank_q <= stV;
                // active only between SAV and EAV
                active_q <= savSeen && synced_q;
            end
            if (fieldOne) begin
                synced_q <= 1'b1;
            end
            // count active lines per frame; frame start wins
            if (newFrame) begin
                lineCnt_q <= '0;
            end else if (savSeen && synced_q) begin
                lineCnt_q <= lineCnt_q + CNT_W'(1);
            end
        end
    end

    // capture selection per submode
    wire gpTake  = gpIn && state_q == ST_XFER;
    // preamble words never reach the mover except in MODE_ITU_ALL, which skips this test
    wire payload = !inTrs && !trsWord;
    // a zero count lets every active line through
    wire lineOk  = (count_q == '0) || (lineCnt_q <= count_q);
    // active mode takes payload inside active lines only
    wire actTake = (mode == MODE_ITU_ACT) && active_q && payload && lineOk;
    wire vbiTake = (mode == MODE_ITU_VBI) && synced_q && vblank_q && payload;
    wire allTake = (mode == MODE_ITU_ALL) && synced_q;
    wire take    = enable && (gpTake || actTake || vbiTake || allTake);
    wire capStrobe = pclkRise && take;

    // one word per port clock, arrival order
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rx_q <= '0;
        end else begin
            rx_q.valid <= capStrobe;
            if (capStrobe) begin
                rx_q.word <= din;
            end
        end
    end
    assign rxWord = rx_q;

    // line length covers the sync, the delay and the samples
    wire [CNT_W-1:0] lineLen  = count_q + delay_q + CNT_W'(CAP_HSYNC_W);
    wire             lastLine = (capLine_q == CNT_W'(CAP_LINES - 1));

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pixCnt_q  <= '0;
            capLine_q <= '0;
        end else if (!enable || !isCap) begin
            pixCnt_q  <= '0;
            capLine_q <= '0;
        end else if (pclkRise) begin
            if (pixCnt_q >= lineLen) begin
                pixCnt_q <= '0;
                if (lastLine) begin
                    capLine_q <= '0;
                end else begin
                    capLine_q <= capLine_q + CNT_W'(1);
                end
            end else begin
                pixCnt_q <= pixCnt_q + CNT_W'(1);
            end
        end
    end

    // hsync leads each line, vsync spans line zero
    wire capH = isCap && pixCnt_q < CNT_W'(CAP_HSYNC_W);
    wire capV = isCap && capLine_q == '0;

    wire outXfer  = isOut && state_q == ST_XFER;
    wire outLoad  = outXfer && txWord.valid;
    // syncs mark the first word of a block
    wire outFirst = outXfer && (xferCnt_q == count_q);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            out_q <= '0;
        end else if (pclkRise) begin
            if (outLoad) begin
                out_q.data <= maskWidth(txWord.word, width);
            end
            // output mode pulses all three lines, capture drives the top one low; the enables decide how many reach pins
            if (isCap) begin
                out_q.fs <= {1'b0, capV, capH};
            end else begin
                out_q.fs <= {3{outFirst}};
            end
        end
    end
    assign pinOut = out_q;

    assign fsOe[0] = enable && (isCap || isOut);
    // sync count field widens the output set
    wire   twoSyncs   = (fsNum >= 2'd1);
    wire   threeSyncs = (fsNum >= 2'd2);

    assign fsOe[1] = enable && (isCap || (isOut && twoSyncs));
    assign fsOe[2] = enable && isOut && threeSyncs;
    assign dataOe  = enable && isOut;
    // a word is taken only when one is offered, so the handshake never runs ahead
    assign txReady = outLoad && pclkRise;

endmodule : pvdp_port

// ### hw/pvdp_pkg.sv
// Purpose: shared constants and types for the parallel video data port
// Assumes: registers reached over a plain address/strobe port, 32-bit data
// Notes: port clock sampled by the system clock
package pvdp_pkg;

    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam int PIN_W  = 16;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_CONTROL = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_DELAY   = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_COUNT   = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_STATUS  = 4'hC;

    // control fields
    localparam int CTL_EN      = 0;
    localparam int CTL_MODE_LO = 1;
    localparam int CTL_MODE_HI = 3;
    localparam int CTL_FSN_LO  = 4;
    localparam int CTL_FSN_HI  = 5;
    localparam int CTL_WID_LO  = 8;
    localparam int CTL_WID_HI  = 11;
    localparam logic [DATA_W-1:0] CTL_RESET = 32'h0000_0000;

    // port modes
    localparam logic [2:0] MODE_GP_IN   = 3'h0;
    localparam logic [2:0] MODE_GP_CAP  = 3'h1;
    localparam logic [2:0] MODE_GP_OUT  = 3'h2;
    localparam logic [2:0] MODE_ITU_ACT = 3'h4;
    localparam logic [2:0] MODE_ITU_VBI = 3'h5;
    localparam logic [2:0] MODE_ITU_ALL = 3'h6;

    // width code: 0 is 8 bits, 2..8 is 10..16 bits
    localparam logic [3:0] WID_8 = 4'h0;

    // frame capture sync timing: hsync width in port clock cycles, frame height in lines
    localparam int CAP_HSYNC_W = 4;
    localparam int CAP_LINES   = 16;

    typedef struct packed {
        logic [PIN_W-1:0] data;
        logic [2:0]       fs;
    } pvdp_pins_t;

    typedef struct packed {
        logic [PIN_W-1:0] word;
        logic             valid;
    } pvdp_word_t;

endpackage : pvdp_pkg

// ### tb/pvdp_port_assertions.sv
// Purpose: pin and handshake checks for the video port
// Assumes: control register shadowed from register writes
// Notes: output enables compared against the shadow
`timescale 1ns/1ps
module pvdp_checker
    import pvdp_pkg::*;
(
    // clock and reset
    input wire logic              clk,
    input wire logic              rstn,
    // register port
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWdata,
    input wire logic              regWr,
    input wire logic              regRd,
    input wire logic [DATA_W-1:0] regRdata,
    // pins and mover
    input wire logic              portClock,
    input wire pvdp_pins_t        pinIn,
    input wire pvdp_pins_t        pinOut,
    input wire logic [2:0]        fsOe,
    input wire logic              dataOe,
    input wire pvdp_word_t        rxWord,
    input wire pvdp_word_t        txWord,
    input wire logic              txReady
);
    logic [DATA_W-1:0] ctlQ;
    logic [2:0]        modeW;
    logic [1:0]        fsnW;
    logic              enW;
    logic              outW;
    assign modeW = ctlQ[CTL_MODE_HI:CTL_MODE_LO];
    assign fsnW  = ctlQ[CTL_FSN_HI:CTL_FSN_LO];
    assign enW   = ctlQ[CTL_EN];
    assign outW  = enW && modeW == MODE_GP_OUT;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) ctlQ <= CTL_RESET;
        else if (regWr && regAddr == OFS_CONTROL) ctlQ <= regWdata;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    a_rx_pulse: assert property (rxWord.valid |=> !rxWord.valid)
        else $error("capture pulse longer than one cycle");
    a_tx_pulse: assert property (txReady |=> !txReady)
        else $error("consume pulse longer than one cycle");
    a_tx_drive: assert property (txReady |=> pinOut.data == $past(txWord.word))
        else $error("consumed word not driven next cycle");
    a_tx_mode: assert property (txReady |-> outW)
        else $error("word consumed outside output mode");
    a_oe_input: assert property (enW && modeW == MODE_GP_IN |-> fsOe == 3'h0 && !dataOe)
        else $error("pin driven in input mode");
    a_oe_capture: assert property (enW && modeW == MODE_GP_CAP |-> fsOe[1:0] == 2'h3 && !dataOe)
        else $error("capture syncs or data direction wrong");
    a_oe_output: assert property (outW |-> dataOe && fsOe == (fsnW == 2'h0 ? 3'h1 :
        fsnW == 2'h1 ? 3'h3 : 3'h7))
        else $error("output sync count wrong");
    a_half_duplex: assert property (outW && $past(outW, 8) |-> !rxWord.valid)
        else $error("capture while in output mode");
    c_rx: cover property (rxWord.valid);
    c_tx: cover property (txReady);
    c_hsync: cover property (enW && modeW == MODE_GP_CAP && pinOut.fs[0]);
    c_itu: cover property (enW && modeW[2] && rxWord.valid);
endmodule : pvdp_checker

// ### tb/pvdp_source.sv
// Purpose: video source model driving syncs and data
// Assumes: port clock runs free like a video pixel clock
// Notes: data counts port clocks since the last sync
`timescale 1ns/1ps
module pvdp_source
    import pvdp_pkg::*;
(
    // request
    input  wire logic start,
    input  wire logic itu,
    // link
    output logic       portClock,
    output pvdp_pins_t pins
);
    logic [PIN_W-1:0] idx    = '0;
    logic [1:0]       fsLeft = '0;
    initial begin
        portClock = 1'b0;
        forever #100 portClock = ~portClock;
    end
    // sixteen-word loop: field two reference, data, field one reference, data
    wire [3:0] pos  = idx[3:0];
    wire [7:0] trs  = (pos[1:0] == 2'h0) ? 8'hFF : (pos[1:0] != 2'h3) ? 8'h00 :
                      (pos[3] ? 8'h20 : 8'h60);
    wire [7:0] ituW = pos[2] ? 8'h10 + 8'(pos) : trs;
    assign pins.data = itu ? {8'h00, ituW} : idx;
    assign pins.fs   = {2'b00, fsLeft != 2'h0};
    // changes on falling edge, stable at the sampling edge
    always @(negedge portClock) begin
        if (start) begin
            idx    <= '0;
            fsLeft <= 2'h2;
        end else begin
            idx <= idx + 16'h1;
            if (fsLeft != 2'h0) fsLeft <= fsLeft - 2'h1;
        end
    end
endmodule : pvdp_source

// ### tb/testbench.sv
// Purpose: self-checking bench for the video port
// Assumes: source model supplies the port clock
// Notes: register tasks follow the strobe protocol
`timescale 1ns/1ps
module testbench;
    import pvdp_pkg::*;
    logic              clk, rstn, regWr, regRd, start, portClock, dataOe, txReady;
    logic [ADDR_W-1:0] regAddr;
    logic [DATA_W-1:0] regWdata, regRdata;
    logic [2:0]        fsOe;
    pvdp_pins_t        pinIn, pinOut;
    pvdp_word_t        rxWord, txWord;
    logic [PIN_W-1:0]  rxQ[$];
    logic              hs, vs, itu;
    logic [7:0]        expAll [8] = '{8'h1C, 8'h1D, 8'h1E, 8'h1F, 8'hFF, 8'h00, 8'h00, 8'h60};
    logic [7:0]        expVbi [8] = '{8'h1C, 8'h1D, 8'h1E, 8'h1F, 8'h14, 8'h15, 8'h16, 8'h17};
    int                n_fail = 0, num_checks = 0, cycles = 0;
    pvdp_port dut (.clk(clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .portClock(portClock),
        .pinIn(pinIn), .pinOut(pinOut), .fsOe(fsOe), .dataOe(dataOe), .rxWord(rxWord),
        .txWord(txWord), .txReady(txReady));
    pvdp_source src (.start(start), .itu(itu), .portClock(portClock), .pins(pinIn));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (rxWord.valid === 1'b1) rxQ.push_back(rxWord.word);
        if (cycles == 20000) begin
            n_fail++;
            end_sim();
        end
    end
    task automatic end_sim;
        $display("checks %0d failures %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : end_sim
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        regAddr  <= a;
        regWdata <= d;
        regWr    <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e, input string nm);
        @(posedge clk);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1 chk(nm, e, regRdata);
    endtask : rd
    task automatic send(input logic [PIN_W-1:0] w, input logic f);
        int k;
        k = 0;
        @(posedge clk);
        txWord <= '{word: w, valid: 1'b1};
        do begin
            @(posedge clk);
            k++;
        end while (txReady !== 1'b1 && k < 200);
        txWord.valid <= 1'b0;
        #1 chk("txData", {16'h0, w}, {16'h0, pinOut.data});
        chk("txSync", {31'h0, f}, {31'h0, pinOut.fs[0]});
    endtask : send
    function automatic logic [DATA_W-1:0] ctl(input logic [2:0] m, input logic [1:0] n);
        return {20'h0, 4'h8, 2'b00, n, m, 1'b1};
    endfunction : ctl
    initial begin
        {rstn, regWr, regRd, regAddr, regWdata, start, txWord, hs, vs, itu} = '0;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        rd(OFS_CONTROL, CTL_RESET, "ctlReset");
        wr(OFS_COUNT, 32'h0000_0005);
        rd(OFS_COUNT, 32'h0000_0005, "count");
        wr(4'h2, 32'hFFFF_FFFF);
        rd(4'h2, 32'h0000_0000, "unmapped");
        for (int d = 3; d >= 0; d -= 3) begin
            wr(OFS_DELAY, DATA_W'(d));
            rd(OFS_DELAY, DATA_W'(d), "delay");
            wr(OFS_CONTROL, ctl(MODE_GP_IN, 2'h0));
            #1 chk("inOe", 32'h0, {28'h0, fsOe, dataOe});
            rxQ.delete();
            start <= 1'b1;
            repeat (8) @(posedge clk);
            start <= 1'b0;
            for (int k = 0; k < 400 && rxQ.size() < 5; k++) @(posedge clk);
            // extra time so a surplus sample would show
            repeat (100) @(posedge clk);
            chk("rxCount", 32'h5, 32'(rxQ.size()));
            // first sample read lies d+1 words past the word at the sync edge
            foreach (rxQ[i]) chk("rxData", 32'(d + 1 + i), {16'h0, rxQ[i]});
        end
        wr(OFS_CONTROL, ctl(MODE_GP_CAP, 2'h0));
        #1 chk("capOe", 32'h6, {29'h0, fsOe[1:0], dataOe});
        for (int k = 0; k < 3000; k++) begin
            @(posedge clk);
            hs |= pinOut.fs[0] === 1'b1;
            vs |= pinOut.fs[1] === 1'b1;
        end
        chk("syncs", 32'h3, {30'h0, vs, hs});
        itu <= 1'b1;
        for (int m = 0; m < 3; m++) begin
            wr(OFS_CONTROL, ctl(MODE_GP_IN, 2'h0));
            rxQ.delete();
            wr(OFS_CONTROL, ctl(3'(MODE_ITU_ACT + m), 2'h0) & ~32'h0000_0F00);
            repeat (600) @(posedge clk);
            if (m == 0) chk("ituAct", 32'h0, 32'(rxQ.size()));
            for (int i = 0; i < 8 && m > 0; i++)
                chk("ituData", 32'(m == 1 ? expVbi[i] : expAll[i]), 32'(rxQ[i]));
        end
        for (int n = 0; n < 3; n++) begin
            wr(OFS_CONTROL, ctl(MODE_GP_OUT, 2'(n)));
            #1 chk("outOe", 32'((1 << (n + 1)) * 2 - 1), {28'h0, fsOe, dataOe});
        end
        send(16'hA5C3, 1'b1);
        send(16'h0000, 1'b0);
        send(16'hFFFF, 1'b0);
        end_sim();
    end
endmodule : testbench
bind pvdp_port pvdp_checker uChecker (.clk(clk), .rstn(rstn), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .portClock(portClock), .pinIn(pinIn), .pinOut(pinOut), .fsOe(fsOe), .dataOe(dataOe),
    .rxWord(rxWord), .txWord(txWord), .txReady(txReady));
